// file: bench/cdac_core_assertions.sv
// pin-level checks for the converter core
`timescale 1ns/1ps
module cdac_core_assertions (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_LATCH,
    input wire logic I_CLEAR,
    input wire logic I_CURRENT_OUTPUT_PIN_FAULT,
    input wire logic I_OVERTEMP,
    input wire logic O_SDO_OE,
    input wire logic O_FAULT,
    input wire logic O_FAULT_OE,
    input wire logic [15:0] O_DAC_CODE,
    input wire logic O_OUT_EN,
    input wire cdac_pkg::cdac_range_t O_RANGE,
    input wire logic O_EXT_CURRENT_SETTING_RESISTOR
);
    import cdac_pkg::*;
    // inputs pass two sync stages and an output flop, so six or more cycles of history
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    AST_PIN_LOW: assert property (O_FAULT == 1'b0)
        else $error("fault pin level not low");
    AST_FAULT_SET: assert property
        ((I_CURRENT_OUTPUT_PIN_FAULT || I_OVERTEMP) [*6] |-> O_FAULT_OE)
        else $error("fault pin not pulled low");
    AST_FAULT_REL: assert property
        ((!I_CURRENT_OUTPUT_PIN_FAULT && !I_OVERTEMP) [*6] |-> !O_FAULT_OE)
        else $error("fault pin not released");
    AST_EN_RANGE: assert property
        (O_OUT_EN |-> O_RANGE != CDAC_RNG_OFF)
        else $error("output enabled with no valid range");
    AST_RST_ZERO: assert property ($rose(I_RST_N) |->
        (O_DAC_CODE == 16'h0000 && !O_FAULT_OE && !O_SDO_OE &&
        !O_OUT_EN && !O_EXT_CURRENT_SETTING_RESISTOR && O_RANGE == CDAC_RNG_OFF))
        else $error("outputs not cleared by reset");
    AST_CLR_DOWN: assert property
        (I_CLEAR [*8] |=> O_DAC_CODE <= $past(O_DAC_CODE))
        else $error("code rose while clear held");
    AST_CLR_HOLD: assert property
        ((I_CLEAR [*8] ##0 O_DAC_CODE == 16'h0000) |=>
        O_DAC_CODE == 16'h0000)
        else $error("code left bottom while clear held");
    AST_CTRL_HOLD: assert property (I_LATCH [*8] |=>
        $stable(O_RANGE) && $stable(O_EXT_CURRENT_SETTING_RESISTOR) && $stable(O_OUT_EN))
        else $error("control outputs moved without a frame");
endmodule // cdac_core_assertions

bind cdac_core cdac_core_assertions cdac_core_assertions_inst (
    .I_CLK, .I_RST_N, .I_LATCH, .I_CLEAR, .I_CURRENT_OUTPUT_PIN_FAULT, .I_OVERTEMP,
    .O_SDO_OE, .O_FAULT, .O_FAULT_OE, .O_DAC_CODE, .O_OUT_EN, .O_RANGE,
    .O_EXT_CURRENT_SETTING_RESISTOR);

// file: bench/cdac_host.sv
// host model: frames on the serial link, readback capture
`timescale 1ns/1ps
module cdac_host (
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sclk,
    output logic o_sdin,
    output logic o_latch
);
    logic [23:0] rx_r;
    logic sdo_w;
    // no pull on the line, so a released output reads as a moving pattern
    assign sdo_w = i_sdo_oe ? i_sdo : ~rx_r[0];
    initial begin
        o_sclk = 1'b0;
        o_sdin = 1'b0;
        o_latch = 1'b1;
        rx_r = 24'h0;
    end
    // n bits msb first, clock idles low; n of zero is a bare latch pulse
    task automatic send(input logic [23:0] w, input int n);
        @(posedge i_clk);
        o_latch <= 1'b0;
        repeat (4) @(posedge i_clk);
        // the core moves its output on each clock rise, so each bit is
        // taken just before the rise that would replace it
        for (int i = n - 1; i >= 0; i--) begin
            rx_r <= {rx_r[22:0], sdo_w};
            o_sclk <= 1'b1;
            o_sdin <= w[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        o_latch <= 1'b1;
        o_sdin <= ~o_sdin;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // cdac_host

// file: bench/testbench.sv
// self-checking bench for the converter register core
`timescale 1ns/1ps
`include "cdac_regs.svh"
module testbench;
    import cdac_pkg::*;
    typedef struct {
        logic [2:0] k;
        logic [15:0] v;
    } cdac_exp_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clear = 1'b0;
    logic ifault = 1'b0;
    logic otemp = 1'b0;
    logic chk = 1'b0;
    logic sclk, sdin, latch, sdo, sdo_oe, fault_oe, out_en, ext_current_setting_resistor;
    logic [15:0] code, code12, meas, got, d, t, c0;
    cdac_range_t range;
    cdac_exp_t e;
    cdac_exp_t q[$];
    int bad_count = 0;
    int tests_run = 0;
    int r, n;
    int fr[16] = '{`CDAC_F0, `CDAC_F1, `CDAC_F2, `CDAC_F3, `CDAC_F4,
        `CDAC_F5, `CDAC_F6, `CDAC_F7, `CDAC_F8, `CDAC_F9, `CDAC_F10,
        `CDAC_F11, `CDAC_F12, `CDAC_F13, `CDAC_F14, `CDAC_F15};

    always #50 clk = ~clk;

    cdac_core cdac_core_inst (
        .I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SDIN(sdin),
        .I_LATCH(latch), .I_CLEAR(clear), .I_CURRENT_OUTPUT_PIN_FAULT(ifault),
        .I_OVERTEMP(otemp), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_FAULT(),
        .O_FAULT_OE(fault_oe), .O_DAC_CODE(code), .O_OUT_EN(out_en),
        .O_RANGE(range), .O_EXT_CURRENT_SETTING_RESISTOR(ext_current_setting_resistor));
    // 12-bit variant on the same link, only its code is watched
    cdac_core #(.RES16(1'b0)) cdac_core12_inst (
        .I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SDIN(sdin),
        .I_LATCH(latch), .I_CLEAR(clear), .I_CURRENT_OUTPUT_PIN_FAULT(ifault),
        .I_OVERTEMP(otemp), .O_SDO(), .O_SDO_OE(), .O_FAULT(),
        .O_FAULT_OE(), .O_DAC_CODE(code12), .O_OUT_EN(), .O_RANGE(),
        .O_EXT_CURRENT_SETTING_RESISTOR());
    cdac_host cdac_host_inst (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_sclk(sclk), .o_sdin(sdin), .o_latch(latch));

    task automatic compare(input logic [15:0] g, input logic [15:0] x);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("BAD %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // note a result; the watcher compares it on the next edge
    task automatic expect_v(input logic [2:0] k, input logic [15:0] v);
        @(posedge clk);
        q.push_back('{k, v});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
        // one more edge so the caller cannot move meas under the watcher
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        cdac_host_inst.send({a, v}, 24);
        repeat (6) @(posedge clk);
    endtask
    // read command, then a no-op frame that shifts the word out
    task automatic rd(input logic [1:0] s);
        wr(8'h02, {14'h0, s});
        wr(8'h00, 16'h0000);
    endtask
    // sampled on the falling edge so the design's updates have landed
    task automatic wait_chg(output int cnt);
        logic [15:0] c;
        c = code;
        cnt = 0;
        while (code === c && cnt < 4000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 4000) begin
            bad_count++;
            end_of_test();
        end
    endtask

    // watcher: takes the oldest note and compares the matching output
    always @(posedge clk) begin
        if (chk === 1'b1) begin
            e = q.pop_front();
            case (e.k)
                3'd0: got = code;
                3'd1: got = cdac_host_inst.rx_r[15:0];
                3'd2: got = {11'h0, fault_oe, out_en, range, ext_current_setting_resistor};
                3'd3: got = meas;
                default: got = code12;
            endcase
            compare(got, e.v);
        end
    end

    // hang guard, well above the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        r = $urandom(32'hdfedb627);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        expect_v(3'd0, 16'h0000);
        expect_v(3'd2, 16'h0000);
        // range codes 000, 101, 110, 111 with the top bits sent high
        for (int i = 0; i < 4; i++) begin
            wr(8'h55, 16'hf000 | 16'(i > 0 ? i + 4 : 0));
            expect_v(3'd2, {12'h0, i > 0, 2'(i), 1'b1});
        end
        rd(2'h2);
        expect_v(3'd1, 16'h3007);
        d = 16'($urandom) | 16'h8000;
        wr(8'h01, d);
        expect_v(3'd0, d);
        expect_v(3'd4, d & `CDAC_MASK12);
        rd(2'h1);
        expect_v(3'd1, d);
        // clear held well past its minimum, a write tried meanwhile
        clear <= 1'b1;
        repeat (10) @(posedge clk);
        expect_v(3'd0, 16'h0000);
        wr(8'h01, ~d);
        expect_v(3'd0, 16'h0000);
        clear <= 1'b0;
        repeat (10) @(posedge clk);
        expect_v(3'd0, 16'h0000);
        cdac_host_inst.send(24'h0, 0);
        repeat (6) @(posedge clk);
        expect_v(3'd0, d);
        // every fault combination, pin and status
        for (int i = 0; i < 4; i++) begin
            {ifault, otemp} <= 2'(i);
            repeat (8) @(posedge clk);
            expect_v(3'd2, {11'h0, i > 0, 4'hf});
            rd(2'h0);
            expect_v(3'd1, {13'h0, i[1], 1'b0, i[0]});
        end
        {ifault, otemp} <= 2'b00;
        // each rate code with a step code: update spacing and size
        for (int i = 0; i < 16; i++) begin
            wr(8'h55, 16'h1017 | 16'(i << 8) | 16'((i % 8) << 5));
            wr(8'h01, i[0] ? 16'hffff : 16'h0000);
            wait_chg(n);
            c0 = code;
            wait_chg(n);
            meas = 16'(n);
            expect_v(3'd3, 16'(`CDAC_CLK_HZ / fr[i]));
            meas = code > c0 ? code - c0 : c0 - code;
            expect_v(3'd3, 16'(1 << (i % 8)));
        end
        // long slew to a target off the step grid
        wr(8'h55, 16'h10f7);
        @(negedge clk);
        t = (code ^ 16'h8000) + 16'h0035;
        wr(8'h01, t);
        rd(2'h0);
        expect_v(3'd1, 16'h0002);
        for (n = 0; n < 12000 && code !== t; n++) begin
            @(negedge clk);
        end
        if (n == 12000) begin
            bad_count++;
            end_of_test();
        end
        repeat (100) @(posedge clk);
        expect_v(3'd0, t);
        rd(2'h0);
        expect_v(3'd1, 16'h0000);
        // reset word with bit 0 low does nothing, with it high resets all
        wr(8'h56, 16'hfffe);
        expect_v(3'd2, 16'h000e);
        wr(8'h56, 16'h0001);
        expect_v(3'd0, 16'h0000);
        expect_v(3'd2, 16'h0000);
        end_of_test();
    end
endmodule // testbench

// file: rtl/cdac_core.sv
// register core of the serial current-output converter
// Notes on behaviour
// [R1] 12-bit variant keeps data bits 15..4, drops bits 3..0.
// [R2] 16-bit variant keeps all sixteen data bits.
// [R3] control word: 15,14 zero, then resistor, enable, rate, step, slew, chain, range.
// [R4] address 0x56 writes the reset register; only bit 0 matters.
// [R5] writing one to the reset bit returns everything but the input synchronisers to power-on state.
// [R6] status word read-only: bit2 pin fault, bit1 slewing, bit0 overtemp.
// [R7] pin fault status follows the output fault detector.
// [R8] slewing status high while the engine steps, only with slew enabled.
// [R9] overtemp status follows the on-chip temperature indication.
// [R10] fault pin active on pin fault or overtemp.
// [R11] the two status bits show which condition drives the fault pin.
// [R12] while clear is high the output goes to range bottom.
// [R13] host holds clear high for its minimum time.
// [R14] after clear falls the output stays cleared.
// [R15] latch pulse with no clocks restores the pre-clear code.
// [R16] data writes are refused while clear is high.
// [R17] resistor select bit picks external or internal setting resistor.
// [R18] with slew enabled the code moves in steps, not in one jump.
// [R19] rate field sets update pace, step field sets step size.
// [R20] range 101 is 4-20, 110 is 0-20, 111 is 0-24 mA.
// [R21] rate code 0000 fastest, 1111 slowest, from a fixed table.
// [R22] step code 000 is one LSB, each code doubles, 111 is 128.
// [R23] power-on loads zero everywhere except the latch synchroniser bits, which load one; output disabled.
// [R24] each tick moves toward target, stops exactly on it.
// [R25] fault pin pulled low on fault, released otherwise.
`timescale 1ns/1ps
`include "cdac_regs.svh"
module cdac_core #(
    parameter bit RES16 = 1'b1,
    parameter int CLK_HZ = `CDAC_CLK_HZ
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_SCLK,
    input wire logic I_SDIN,
    input wire logic I_LATCH,
    input wire logic I_CLEAR,
    input wire logic I_CURRENT_OUTPUT_PIN_FAULT,
    input wire logic I_OVERTEMP,
    output logic O_SDO,
    output logic O_SDO_OE,
    output logic O_FAULT,
    output logic O_FAULT_OE,
    output logic [15:0] O_DAC_CODE,
    output logic O_OUT_EN,
    output cdac_pkg::cdac_range_t O_RANGE,
    output logic O_EXT_CURRENT_SETTING_RESISTOR
);
    import cdac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    // pins are asynchronous: two flops before any logic, third for edges
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic sclk_d_r;
    logic latch_d_r;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            meta_r <= 6'h04;
            sync_r <= 6'h04;
            sclk_d_r <= 1'b0;
            latch_d_r <= 1'b1;
        end else begin
            meta_r <= {I_OVERTEMP, I_CURRENT_OUTPUT_PIN_FAULT, I_CLEAR, I_LATCH,
                       I_SDIN, I_SCLK};
            sync_r <= meta_r;
            sclk_d_r <= sync_r[0];
            latch_d_r <= sync_r[2];
        end
    end

    // named views of the synchronised pins
    wire sclk_s = sync_r[0];
    wire sdin_s = sync_r[1];
    wire latch_s = sync_r[2];
    wire clear_s = sync_r[3];
    wire fault_s = sync_r[4];
    wire otemp_s = sync_r[5];
    wire sclk_fall = sclk_d_r && !sclk_s;
    wire sclk_rise = !sclk_d_r && sclk_s;
    wire latch_rise = !latch_d_r && latch_s;

    ////////////////////////////////////////////////////////////////////////
    // state declarations

    logic soft_r;
    logic [23:0] sr_r;
    logic [4:0] bits_r;
    logic [23:0] out_r;
    logic [15:0] data_r;
    logic [15:0] ctrl_r;
    logic clr_hold_r;
    logic fault_oe_r;
    cdac_rb_t rb_r;
    cdac_rb_t rb_nxt;

    // power-on and register-driven reset share one path
    wire rst = !I_RST_N || soft_r; // see [R5]

    cdac_slew_if sl ();

    cdac_slew #(
        .CLK_HZ(CLK_HZ)
    ) u_slew (
        .i_clk(I_CLK),
        .i_rst(rst),
        .sl(sl)
    );

    ////////////////////////////////////////////////////////////////////////
    // frame decode

    // a frame counts only with at least 24 clocks since the last latch
    wire frame_ok = bits_r >= 5'd24;
    wire [7:0] addr = sr_r[23:16];
    wire [15:0] word = sr_r[15:0];
    wire hit_data = latch_rise && frame_ok && addr == `CDAC_ADDR_DATA;
    wire hit_ctrl = latch_rise && frame_ok && addr == `CDAC_ADDR_CTRL;
    wire hit_rst = latch_rise && frame_ok && addr == `CDAC_ADDR_RESET;
    wire hit_read = latch_rise && frame_ok && addr == `CDAC_ADDR_READ;
    // clear must be low before a new code is taken
    wire wr_data = hit_data && !clear_s; // see [R16]
    wire do_soft = hit_rst && word[`CDAC_B_RESET]; // see [R4]
    // latch pulse with no clocks after clear falls, while the clear hold is still set
    wire restore = latch_rise && bits_r == 5'd0 && clr_hold_r
                   && !clear_s; // see [R15]

    // data word masked per variant
    wire [15:0] data_in = RES16 ? word // see [R2]
                                : word & `CDAC_MASK12; // see [R1]

    ////////////////////////////////////////////////////////////////////////
    // control fields

    wire ext_current_setting_resistor = ctrl_r[`CDAC_B_EXT_RESISTOR_SELECT];
    wire out_en = ctrl_r[`CDAC_B_OUTPUT_DRIVE_ENABLE];
    wire [3:0] rate = ctrl_r[`CDAC_B_RATE_HI:`CDAC_B_RATE_LO];
    wire [2:0] step = ctrl_r[`CDAC_B_STEP_HI:`CDAC_B_STEP_LO];
    wire slew_en = ctrl_r[`CDAC_B_SLEW_CONTROL_ENABLE];
    wire chain_en = ctrl_r[`CDAC_B_CHAIN_MODE_ENABLE];
    wire [2:0] range_code = ctrl_r[`CDAC_B_RANGE_HI:`CDAC_B_RANGE_LO];

    // range decode; unlisted codes leave no valid range
    wire cdac_range_t range_dec =
        (range_code == 3'b101) ? CDAC_RNG_4_20 : // see [R20]
        (range_code == 3'b110) ? CDAC_RNG_0_20 : // see [R20]
        (range_code == 3'b111) ? CDAC_RNG_0_24 : // see [R20]
        CDAC_RNG_OFF;

    // status word, reserved bits read zero
    wire [15:0] status = {13'h0000, fault_s, sl.active,
                          otemp_s}; // see [R6] [R7] [R8] [R9] [R11]

    // readback selection
    wire [1:0] rd_sel = word[1:0];
    wire [15:0] rd_val = (rd_sel == `CDAC_RD_STATUS) ? status :
                         (rd_sel == `CDAC_RD_DATA) ? data_r :
                         (rd_sel == `CDAC_RD_CTRL) ? ctrl_r : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // slew engine hookup

    // code zero is the bottom of every range, clear drives toward it
    assign sl.target = clr_hold_r ? 16'h0000 : data_r; // see [R12] [R14]
    assign sl.enable = slew_en; // see [R18]
    assign sl.rate = rate; // see [R19]
    assign sl.step = step; // see [R19]

    ////////////////////////////////////////////////////////////////////////
    // serial input shift

    // data is sampled on the falling clock edge; count saturates
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            sr_r <= 24'h000000;
            bits_r <= 5'h00;
        end else begin
            if (sclk_fall) begin
                sr_r <= {sr_r[22:0], sdin_s};
            end
            if (latch_rise) begin
                bits_r <= 5'h00;
            end else if (sclk_fall && bits_r != 5'h1f) begin
                bits_r <= bits_r + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset register

    // one-cycle pulse; it resets everything but the input synchronisers, itself included
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            soft_r <= 1'b0;
        end else begin
            soft_r <= do_soft; // see [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data, control and clear hold

    // outside a clear hold, a control write mid-slew halts the output where it stands
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            data_r <= `CDAC_DATA_RESET; // see [R23]
            ctrl_r <= `CDAC_CTRL_RESET; // see [R23]
            clr_hold_r <= 1'b0;
        end else begin
            if (wr_data) begin
                data_r <= data_in;
            end else if (hit_ctrl && sl.active && !clr_hold_r) begin
                data_r <= sl.code;
            end
            if (hit_ctrl) begin
                ctrl_r <= word & `CDAC_CTRL_WMASK; // see [R3]
            end
            // clear wins over any release in the same cycle
            if (clear_s) begin
                clr_hold_r <= 1'b1; // see [R12]
            end else if (wr_data || restore) begin
                clr_hold_r <= 1'b0; // see [R14] [R15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback output

    // the latch that ends a read command opens the output, next closes it
    always_comb begin
        rb_nxt = rb_r;
        if (hit_read) begin
            rb_nxt = CDAC_RB_SHIFT;
        end else if (latch_rise) begin
            rb_nxt = CDAC_RB_OFF;
        end
    end

    // output data moves on the rising clock so the host samples it just before each rise
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            rb_r <= CDAC_RB_OFF;
            out_r <= 24'h000000;
        end else begin
            rb_r <= rb_nxt;
            if (hit_read) begin
                out_r <= {8'h00, rd_val}; // see [R6]
            end else if (sclk_rise && rb_r == CDAC_RB_SHIFT) begin
                out_r <= {out_r[22:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault pin

    // open drain: level is always low, only the enable moves
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            fault_oe_r <= 1'b0;
        end else begin
            fault_oe_r <= fault_s || otemp_s; // see [R10] [R25]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // in chain mode the input shift register feeds the next device
    assign O_SDO = chain_en ? sr_r[23] : out_r[23];
    assign O_SDO_OE = chain_en || rb_r == CDAC_RB_SHIFT;
    assign O_FAULT = 1'b0; // see [R25]
    assign O_FAULT_OE = fault_oe_r;
    assign O_DAC_CODE = sl.code;
    // no valid range keeps the stage off as well
    assign O_OUT_EN = out_en && range_dec != CDAC_RNG_OFF; // see [R23]
    assign O_RANGE = range_dec;
    assign O_EXT_CURRENT_SETTING_RESISTOR = ext_current_setting_resistor; // see [R17]

endmodule // cdac_core

// file: rtl/cdac_pkg.sv
// types shared by the converter core and its bench
package cdac_pkg;

    // decoded output range, off for any unlisted code
    typedef enum logic [1:0] {
        CDAC_RNG_OFF = 2'b00,
        CDAC_RNG_4_20 = 2'b01,
        CDAC_RNG_0_20 = 2'b10,
        CDAC_RNG_0_24 = 2'b11
    } cdac_range_t;

    // readback output phase
    typedef enum logic {
        CDAC_RB_OFF = 1'b0,
        CDAC_RB_SHIFT = 1'b1
    } cdac_rb_t;

endpackage

// file: rtl/cdac_regs.svh
// register map, field positions, reset values and timing for the converter core
`ifndef CDAC_REGS_SVH
`define CDAC_REGS_SVH

// serial frame: one address byte followed by sixteen data bits
`define CDAC_FRAME_BITS 24
`define CDAC_ADDR_NOP 8'h00
`define CDAC_ADDR_DATA 8'h01
`define CDAC_ADDR_READ 8'h02
`define CDAC_ADDR_CTRL 8'h55
`define CDAC_ADDR_RESET 8'h56

// read address field of a readback command
`define CDAC_RD_STATUS 2'h0
`define CDAC_RD_DATA 2'h1
`define CDAC_RD_CTRL 2'h2

// reset values and write masks
`define CDAC_DATA_RESET 16'h0000
`define CDAC_CTRL_RESET 16'h0000
`define CDAC_CTRL_WMASK 16'h3fff
`define CDAC_MASK12 16'hfff0

// control word fields
`define CDAC_B_EXT_RESISTOR_SELECT 13
`define CDAC_B_OUTPUT_DRIVE_ENABLE 12
`define CDAC_B_RATE_HI 11
`define CDAC_B_RATE_LO 8
`define CDAC_B_STEP_HI 7
`define CDAC_B_STEP_LO 5
`define CDAC_B_SLEW_CONTROL_ENABLE 4
`define CDAC_B_CHAIN_MODE_ENABLE 3
`define CDAC_B_RANGE_HI 2
`define CDAC_B_RANGE_LO 0

// reset register and status word bits
`define CDAC_B_RESET 0
`define CDAC_B_ST_FAULT 2
`define CDAC_B_ST_SLEW 1
`define CDAC_B_ST_OTEMP 0

// core clock and slew update frequencies in Hz
`define CDAC_CLK_HZ 10000000
`define CDAC_F0 257730
`define CDAC_F1 198410
`define CDAC_F2 152440
`define CDAC_F3 131580
`define CDAC_F4 115740
`define CDAC_F5 69440
`define CDAC_F6 37590
`define CDAC_F7 25770
`define CDAC_F8 20160
`define CDAC_F9 16030
`define CDAC_F10 10290
`define CDAC_F11 8280
`define CDAC_F12 6900
`define CDAC_F13 5530
`define CDAC_F14 4240
`define CDAC_F15 3300

`endif

// file: rtl/cdac_slew.sv
// digital slew engine: paces the working code toward the target
`timescale 1ns/1ps
`include "cdac_regs.svh"
module cdac_slew #(
    parameter int CLK_HZ = `CDAC_CLK_HZ
) (
    input wire logic i_clk,
    input wire logic i_rst,
    cdac_slew_if.engine sl
);

    ////////////////////////////////////////////////////////////////////////
    // update divider

    // reload value for each rate code; truncation keeps rate at or above
    function automatic logic [11:0] div_of(input logic [3:0] c);
        int f;
        case (c)
            4'h0: f = `CDAC_F0;
            4'h1: f = `CDAC_F1;
            4'h2: f = `CDAC_F2;
            4'h3: f = `CDAC_F3;
            4'h4: f = `CDAC_F4;
            4'h5: f = `CDAC_F5;
            4'h6: f = `CDAC_F6;
            4'h7: f = `CDAC_F7;
            4'h8: f = `CDAC_F8;
            4'h9: f = `CDAC_F9;
            4'ha: f = `CDAC_F10;
            4'hb: f = `CDAC_F11;
            4'hc: f = `CDAC_F12;
            4'hd: f = `CDAC_F13;
            4'he: f = `CDAC_F14;
            default: f = `CDAC_F15;
        endcase
        return 12'(CLK_HZ / f - 1);
    endfunction

    logic [11:0] cnt_r;
    logic [15:0] code_r;

    // stepping arithmetic
    wire tick = sl.enable && (cnt_r == 12'h000);
    wire up = sl.target > code_r;
    wire [15:0] diff = up ? sl.target - code_r : code_r - sl.target;
    wire [15:0] step_amt = 16'h0001 << sl.step; // see [R22]
    wire [15:0] move = (diff < step_amt) ? diff : step_amt; // see [R24]

    assign sl.code = code_r;
    assign sl.active = sl.enable && (code_r != sl.target); // see [R8]

    ////////////////////////////////////////////////////////////////////////
    // working code

    // disabled: code follows target at once; enabled: one step per tick
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            code_r <= 16'h0000;
            cnt_r <= 12'h000;
        end else if (!sl.enable) begin
            code_r <= sl.target;
            cnt_r <= 12'h000;
        end else begin
            if (tick) begin
                code_r <= up ? code_r + move : code_r - move; // see [R18]
            end
            cnt_r <= tick ? div_of(sl.rate) : cnt_r - 12'h001; // see [R21]
        end
    end

endmodule // cdac_slew

// file: rtl/cdac_slew_if.sv
// link between the register core and the slew engine
`timescale 1ns/1ps
interface cdac_slew_if;
    logic [15:0] target;
    logic enable;
    logic [3:0] rate;
    logic [2:0] step;
    logic [15:0] code;
    logic active;

    modport core (output target, enable, rate, step, input code, active);
    modport engine (input target, enable, rate, step, output code, active);
endinterface
